// >>> hdl/adcis_pkg.sv
`default_nettype none
package adcis_pkg;
  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam int          CLK_MHZ    = 50;      // core clock rate
  localparam int          T_CONV_NS  = 8960;    // conversion phase time
  localparam int          T_ACQ_NS   = 1120;    // acquisition phase time
  localparam int          CONV_CYC   = (T_CONV_NS * CLK_MHZ) / 1000;
  localparam int          ACQ_CYC    = (T_ACQ_NS * CLK_MHZ) / 1000;
  localparam int          RES_W      = 12;      // result width
  localparam logic [3:0]  DEV_CODE   = 4'h5;    // arbitrary device code
  localparam logic [2:0]  ADDR_RST   = 3'h0;    // select bits after reset
  localparam logic [3:0]  BIT_LAST   = 4'h7;    // last bit index of byte
  localparam logic [3:0]  BIT_ACK    = 4'h8;    // ack slot index
endpackage : adcis_pkg
`default_nettype wire

// >>> hdl/adcis_slave.sv
`default_nettype none
module adcis_slave #(
  parameter int RES_W = adcis_pkg::RES_W
) (
  // clock and reset
  input  wire  logic             core_clk,
  input  wire  logic             sys_rst,
  // two-wire bus pins
  input  wire  logic             scl_in,
  input  wire  logic             sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // address select straps
  input  wire  logic             addr_select_bit_hi,
  input  wire  logic             addr_select_bit_mid,
  input  wire  logic             addr_select_bit_lo,
  // digitised analog input sample
  input  wire  logic [RES_W-1:0] analog_input,
  // status
  output logic                   conv_busy,
  output logic [RES_W-1:0]       result
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (RES_W != 12) begin : g_chk
    $error("result width must be 12");
  end

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] scl_sy;   // scl two-stage synchroniser
  logic [1:0] sda_sy;   // sda two-stage synchroniser
  logic       scl_d;    // previous synced scl
  logic       sda_d;    // previous synced sda
  logic [2:0] strap_sy0; // strap first stage
  logic [2:0] strap;     // strap second stage

  // sample pins into core clock
  always_ff @(posedge core_clk) begin
    scl_sy    <= {scl_sy[0], scl_in};
    sda_sy    <= {sda_sy[0], sda_in};
    scl_d     <= scl_sy[1];
    sda_d     <= sda_sy[1];
    strap_sy0 <= {addr_select_bit_hi, addr_select_bit_mid, addr_select_bit_lo};
    strap     <= strap_sy0;
  end

  wire scl_rise = scl_sy[1] & ~scl_d;
  wire scl_fall = ~scl_sy[1] & scl_d;
  // start/stop seen as sda change with scl high
  wire start_ev = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
  wire stop_ev  = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

  // ---------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,   // waiting for start
    S_ADDR = 6'b000010,   // receiving address byte
    S_AACK = 6'b000100,   // acking address
    S_TX   = 6'b001000,   // sending a result byte
    S_MACK = 6'b010000,   // sampling master ack
    S_IGN  = 6'b100000    // ignoring until next start
  } adcis_state_e;

  adcis_state_e state;
  logic [3:0]   bitcnt;    // bit index in byte
  logic [7:0]   shreg;     // address shifter
  logic         rd_dir;    // latched direction
  logic         hi_byte;   // sending first result byte
  logic [7:0]   txbyte;    // byte under transmission
  logic         conv_go;   // one-cycle conversion start

  // byte that goes out for each half of the result
  function automatic logic [7:0] pick_byte(input logic hi, input logic [RES_W-1:0] r);
    pick_byte = hi ? {4'h0, r[11:8]} : r[7:0];
  endfunction : pick_byte

  // byte for the half now being sent, from the newest stored result;
  // the master may hold scl low until a conversion ends, so this is
  // read again until the first bit of the byte has been clocked
  wire logic [7:0] cur_byte = pick_byte(hi_byte, result);

  // bus sequencing: a start always wins over any state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state   <= S_IDLE;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      rd_dir  <= 1'b0;
      hi_byte <= 1'b1;
      conv_go <= 1'b0;
    end else begin
      conv_go <= 1'b0;
      if (start_ev) begin
        // repeated or fresh start
        state  <= S_ADDR;
        bitcnt <= 4'h0;
      end else if (stop_ev) begin
        state <= S_IDLE;
      end else begin
        case (state)
          S_ADDR: begin
            if (scl_rise) begin
              // shift address bit on rising edge
              shreg  <= {shreg[6:0], sda_sy[1]};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == adcis_pkg::BIT_ACK) begin
              bitcnt <= 4'h0;
              if (shreg[7:1] == {adcis_pkg::DEV_CODE, strap}) begin
                state   <= S_AACK;
                rd_dir  <= shreg[0];
                conv_go <= shreg[0];
                hi_byte <= 1'b1;
              end else begin
                state <= S_IGN;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              // ack pulse over: read sends data, write releases
              state <= rd_dir ? S_TX : S_IGN;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bitcnt == adcis_pkg::BIT_LAST) begin
                bitcnt <= 4'h0;
                state  <= S_MACK;
                conv_go <= ~hi_byte;
              end else begin
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              // nak ends the read, ack continues
              if (sda_sy[1]) begin
                state <= S_IGN;
              end
            end else if (scl_fall) begin
              state   <= S_TX;
              hi_byte <= ~hi_byte;
            end
          end
          default: begin
            state <= state;  // idle and ignore wait for start
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // self-timed acquisition and conversion
  // ---------------------------------------------------------------
  localparam int CW = $clog2(adcis_pkg::CONV_CYC + adcis_pkg::ACQ_CYC + 1);
  logic [CW-1:0] tcnt;     // phase timer
  logic          acq_ph;   // in acquisition phase
  logic [RES_W-1:0] held;  // held sample

  // acquisition then conversion, independent of scl
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tcnt      <= '0;
      acq_ph    <= 1'b0;
      conv_busy <= 1'b0;
      held      <= '0;
      result    <= '0;
    end else if (conv_go) begin
      tcnt      <= CW'(adcis_pkg::ACQ_CYC - 1);
      acq_ph    <= 1'b1;
      conv_busy <= 1'b1;
    end else if (conv_busy) begin
      if (tcnt != '0) begin
        tcnt <= tcnt - CW'(1);
      end else if (acq_ph) begin
        // hold the input, start conversion phase
        held   <= analog_input;
        acq_ph <= 1'b0;
        tcnt   <= CW'(adcis_pkg::CONV_CYC - 1);
      end else begin
        result    <= held;
        conv_busy <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // sda driver
  // ---------------------------------------------------------------
  // latch byte at start of each data byte, drive on scl low
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txbyte  <= 8'h00;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;  // open drain: only ever pulls low
      if (state == S_AACK && !scl_sy[1]) begin
        sda_oe <= 1'b1;
        txbyte <= pick_byte(1'b1, result);
      end else if (state == S_MACK && scl_fall) begin
        sda_oe <= 1'b0;
        txbyte <= pick_byte(~hi_byte, result);
      end else if (state == S_TX && !scl_sy[1] && bitcnt == 4'h0 && !scl_fall) begin
        // first bit of a byte: take the freshest result
        txbyte <= cur_byte;
        sda_oe <= ~cur_byte[7];
      end else if (state == S_TX && !scl_sy[1]) begin
        sda_oe <= ~txbyte[3'(adcis_pkg::BIT_LAST - bitcnt)];
      end else if (state == S_TX || state == S_AACK) begin
        sda_oe <= sda_oe;  // hold through scl high
      end else begin
        sda_oe <= 1'b0;    // released, slave only
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ack_low_high: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == S_AACK && scl_sy[1] && scl_d) |-> sda_oe)
    else $error("ack not driven low during scl high");
  a_sda_stable_high: assert property (@(posedge core_clk) disable iff (sys_rst)
    (scl_sy[1] && scl_d && state == S_TX) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  a_release_nak: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == S_MACK && scl_rise && sda_sy[1] && !start_ev && !stop_ev) |=> ##1 !sda_oe)
    else $error("bus not released after nak");
  a_ign_released: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == S_IGN) ##1 (state == S_IGN) |-> !sda_oe)
    else $error("sda driven while ignoring");
  a_conv_len: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(acq_ph) && conv_busy |-> conv_busy [*8])
    else $error("conversion phase too short");
  a_acq_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    conv_go |=> conv_busy && acq_ph)
    else $error("acquisition did not start");
  a_out_driven_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_start_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
    start_ev |=> state == S_ADDR && bitcnt == 4'h0)
    else $error("start not taken");
  a_stop_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    stop_ev && !start_ev |=> state == S_IDLE)
    else $error("stop not taken");

  // ---------------------------------------------------------------
  // multi-step checks
  // ---------------------------------------------------------------
  // the r/w bit of a matching read address has just fallen
  sequence s_read_addr_end;
    state == S_ADDR && scl_fall && bitcnt == adcis_pkg::BIT_ACK
      && shreg == {adcis_pkg::DEV_CODE, strap, 1'b1} && !start_ev && !stop_ev;
  endsequence
  // the start pulse, then acquisition on the following edge
  sequence s_acq_begins;
    ##1 conv_go ##1 (conv_busy && acq_ph);
  endsequence
  a_read_starts_conv: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_read_addr_end |-> s_acq_begins)
    else $error("read address did not start a conversion");

  // device owns the ack slot of a matching address while scl is low
  sequence s_ack_slot;
    state == S_AACK && !scl_sy[1] && !start_ev && !stop_ev;
  endsequence
  a_addr_ack_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_ack_slot |=> sda_oe)
    else $error("address ack not driven");

  // the four leading bits of the first byte are pulled low
  a_zero_nibble: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == S_TX && hi_byte && scl_rise && bitcnt < 4'h4) |-> sda_oe)
    else $error("leading zero bits not sent");

  // a write address is acked, then the line is let go
  a_write_release: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == S_AACK && !rd_dir && scl_fall && !start_ev && !stop_ev) |=> ##1 !sda_oe)
    else $error("bus held after write ack");

  // a write address never starts the converter
  a_no_write_conv: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == S_ADDR && scl_fall && bitcnt == adcis_pkg::BIT_ACK && !shreg[0]) |=> !conv_go)
    else $error("write address started a conversion");

  // helper: cycles spent busy, to check the whole self-timed span
  logic [CW-1:0] busy_cyc;  // busy cycle counter
  always_ff @(posedge core_clk) begin
    if (sys_rst || !conv_busy || conv_go) begin
      busy_cyc <= '0;
    end else begin
      busy_cyc <= busy_cyc + CW'(1);
    end
  end

  // acquisition plus conversion takes exactly the package span
  a_busy_span: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(conv_busy) |-> busy_cyc == CW'(adcis_pkg::ACQ_CYC + adcis_pkg::CONV_CYC))
    else $error("conversion span wrong");
endmodule : adcis_slave
`default_nettype wire

// >>> tb/adc_i2c_slave_readout_bench.sv
`default_nettype none
module adc_i2c_slave_readout_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T_BUSY = adcis_pkg::ACQ_CYC + adcis_pkg::CONV_CYC; // busy span
  logic        core_clk, sys_rst, sda_out, sda_oe, conv_busy, scl, sda_pull, ack, st;
  logic [2:0]  strap;        // select straps
  logic [11:0] analog_input; // sample value
  logic [11:0] result;
  logic [7:0]  rx;
  wire         sda;          // pulled up unless someone drives low
  int          mismatches, cmp_count, cnt;
  assign sda = (sda_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  adcis_slave adcis_slave_inst (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit_hi(strap[2]),
    .addr_select_bit_mid(strap[1]), .addr_select_bit_lo(strap[0]),
    .analog_input(analog_input), .conv_busy(conv_busy), .result(result));
  adcis_master adcis_master_inst (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // hold scl low until the conversion ends, then judge its span
  task automatic conv_wait(input logic [11:0] v);
    cnt = 0;
    while (conv_busy !== 1'b0 && cnt < 2000) begin
      @(posedge core_clk);
      cnt++;
    end
    @(negedge core_clk);
    check((cnt >= T_BUSY - 12) && (cnt <= T_BUSY), 1);
    check(result, v);
  endtask : conv_wait
  // two back-to-back conversions, the second ended by a nak
  task automatic t_read(input logic [11:0] v0, input logic [11:0] v1);
    @(negedge core_clk) analog_input = v0;
    adcis_master_inst.start_cond();
    adcis_master_inst.byte_x({adcis_pkg::DEV_CODE, strap, 1'b1}, 1'b1, rx, ack, st);
    check(ack, 0);
    check(conv_busy, 1);
    conv_wait(v0);
    adcis_master_inst.byte_x(8'hFF, 1'b0, rx, ack, st);
    check(rx, {4'h0, v0[11:8]});
    @(negedge core_clk) analog_input = v1;
    adcis_master_inst.byte_x(8'hFF, 1'b0, rx, ack, st);
    check(rx, v0[7:0]);
    check(st, 1);
    check(conv_busy, 1);
    conv_wait(v1);
    adcis_master_inst.byte_x(8'hFF, 1'b0, rx, ack, st);
    check(rx, {4'h0, v1[11:8]});
    adcis_master_inst.byte_x(8'hFF, 1'b1, rx, ack, st);
    check(rx, v1[7:0]);
    repeat (8) @(negedge core_clk);
    check(sda_oe, 0);
    adcis_master_inst.stop_cond();
    repeat (T_BUSY + 8) @(negedge core_clk);
    check(conv_busy, 0);
  endtask : t_read
  // presence polling over every strap value, stop and restart mixed
  task automatic t_poll;
    for (int s = 0; s < 8; s++) begin
      @(negedge core_clk) strap = s[2:0];
      repeat (4) @(negedge core_clk);
      adcis_master_inst.start_cond();
      adcis_master_inst.byte_x({adcis_pkg::DEV_CODE, s[2:0], 1'b0}, 1'b1, rx, ack, st);
      check(ack, 0);
      repeat (8) @(negedge core_clk);
      check(sda_oe, 0);
      check(conv_busy, 0);
      if (s[0]) adcis_master_inst.stop_cond();
    end
  endtask : t_poll
  // wrong device code, then wrong straps: no ack, line left released
  task automatic t_miss;
    for (int k = 0; k < 2; k++) begin
      adcis_master_inst.start_cond();
      adcis_master_inst.byte_x(k ? {adcis_pkg::DEV_CODE, strap ^ 3'h2, 1'b1}
        : {adcis_pkg::DEV_CODE ^ 4'h1, strap, 1'b1}, 1'b1, rx, ack, st);
      check(ack, 1);
      adcis_master_inst.byte_x(8'hFF, 1'b1, rx, ack, st);
      check(rx, 8'hFF);
      check(conv_busy, 0);
      adcis_master_inst.stop_cond();
    end
  endtask : t_miss
  // -------------------------------------------------------------
  // clock, watchdog and main sequence
  // -------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #500000;
    mismatches++;
    summarize();
  end
  initial begin
    mismatches = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    strap = 3'h5;
    analog_input = 12'h000;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check({sda_oe, conv_busy, result}, 14'h0000);
    t_read(12'hA5C, 12'h3F1);
    t_poll();
    @(negedge core_clk) strap = 3'h5;
    t_miss();
    t_read(12'hFFF, 12'h000);
    summarize();
  end
endmodule : adc_i2c_slave_readout_bench
`default_nettype wire

// >>> tb/adcis_master.sv
`default_nettype none
module adcis_master (
  // bus lines
  output logic      scl,      // bus clock, idle high
  output logic      sda_pull, // high while the master pulls sda low
  input  wire logic sda       // resolved data line
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------
  // bus master: scl stands high between frames
  // -------------------------------------------------------------
  initial begin
    scl      = 1'b1; // both lines high: bus idle
    sda_pull = 1'b0;
  end
  // start or repeated start: sda falls while scl high
  task automatic start_cond;
    #20 sda_pull = 1'b0;
    #60 scl = 1'b1;
    #60 sda_pull = 1'b1;
    #60 scl = 1'b0;
  endtask : start_cond
  // stop: sda rises while scl high
  task automatic stop_cond;
    #20 sda_pull = 1'b1;
    #60 scl = 1'b1;
    #60 sda_pull = 1'b0;
    #80;
  endtask : stop_cond
  // one pulse per bit, sda moved only while scl low
  task automatic bit_x(input logic b, output logic s, output logic st);
    logic first;
    #20 sda_pull = ~b;
    #60 scl = 1'b1;
    #20 first = sda;
    #40 s = sda;
    st = (first === s);
    #20 scl = 1'b0;
  endtask : bit_x
  // eight bits then the ack pulse; ack_tx high releases
  task automatic byte_x(input logic [7:0] tx, input logic ack_tx,
                        output logic [7:0] rx, output logic ack_rx, output logic st);
    logic b;
    logic s1;
    st = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], b, s1);
      rx[i] = b;
      st &= s1;
    end
    bit_x(ack_tx, ack_rx, s1);
    st &= s1;
  endtask : byte_x
endmodule : adcis_master
`default_nettype wire
